// >>> mask_rom_read_port_bench.sv
`timescale 1ns/100ps
module mask_rom_read_port_bench;
   logic sys_clk;
   logic rstn;
   logic req;
   logic [11:0] req_addr;
   logic busy;
   logic rd_valid;
   logic [7:0] rd_data;
   logic [11:0] word_addr;
   logic select_first;
   logic select_second;
   logic [7:0] rd_byte;
   logic busy_b;
   logic rd_valid_b;
   logic [7:0] rd_data_b;
   logic [11:0] word_addr_b;
   logic select_first_b;
   logic select_second_b;
   logic [7:0] rd_byte_b;
   logic [7:0] exp_d;
   logic [11:0] exp_q[$];
   logic [11:0] m_a;
   logic [11:0] fixed [6] = '{12'h000, 12'hFFF, 12'h001, 12'h800,
      12'h555, 12'hAAA};
   logic [3:0] lat = 4'h0;
   int failures = 0;
   int n_checks = 0;
   int ticks = 0;
   mrp_host #(.SEL1_ACT_HIGH(1'b1), .SEL2_ACT_HIGH(1'b0)) dut (
      .sys_clk(sys_clk), .rstn(rstn), .req(req), .req_addr(req_addr),
      .busy(busy), .rd_valid(rd_valid), .rd_data(rd_data),
      .word_addr(word_addr), .select_first(select_first),
      .select_second(select_second), .rd_byte(rd_byte));
   mrp_rom_model #(.SEL1_ACT_HIGH(1'b1), .SEL2_ACT_HIGH(1'b0)) mem (
      .word_addr(word_addr), .select_first(select_first),
      .select_second(select_second), .rd_byte(rd_byte));
   // Opposite select polarities on a second pair
   mrp_host #(.SEL1_ACT_HIGH(1'b0), .SEL2_ACT_HIGH(1'b1)) dut_b (
      .sys_clk(sys_clk), .rstn(rstn), .req(req), .req_addr(req_addr),
      .busy(busy_b), .rd_valid(rd_valid_b), .rd_data(rd_data_b),
      .word_addr(word_addr_b), .select_first(select_first_b),
      .select_second(select_second_b), .rd_byte(rd_byte_b));
   mrp_rom_model #(.SEL1_ACT_HIGH(1'b0), .SEL2_ACT_HIGH(1'b1)) mem_b (
      .word_addr(word_addr_b), .select_first(select_first_b),
      .select_second(select_second_b), .rd_byte(rd_byte_b));
   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   task end_sim;
      $display("Checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task cmp(input logic [11:0] got, input logic [11:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task cmp_addr(input logic [11:0] got, input logic [11:0] exp);
      cmp(got, exp);
   endtask
   task cmp_data(input logic [7:0] got, input logic [7:0] exp);
      cmp({4'h0, got}, {4'h0, exp});
   endtask
   task cmp_sel(input logic [1:0] got, input logic [1:0] exp);
      cmp({10'h000, got}, {10'h000, exp});
   endtask
   task cmp_lat(input logic [3:0] got, input logic [3:0] exp);
      cmp({8'h00, got}, {8'h00, exp});
   endtask
   task do_read(input logic [11:0] ad);
      req <= 1'b1;
      req_addr <= ad;
      exp_q.push_back(ad);
      do @(posedge sys_clk); while (busy !== 1'b0);
      do @(posedge sys_clk); while (busy !== 1'b1);
   endtask
   // Result watcher
   always @(posedge sys_clk)
   begin
      ticks++;
      if (ticks > 1000)
      begin
         failures++;
         end_sim();
      end
      lat <= busy ? lat + 4'h1 : 4'h0;
      if (rstn)
      begin
         cmp_sel({select_first, select_second},
            busy ? 2'h2 : 2'h1);
         cmp_sel({select_first_b, select_second_b},
            busy_b ? 2'h1 : 2'h2);
      end
      if (rstn && rd_valid)
      begin
         m_a = exp_q.size() ? exp_q.pop_front() : ~word_addr;
         exp_d = m_a[7:0] ^ {m_a[3:0], m_a[11:8]} ^ 8'h3C;
         cmp_addr(word_addr, m_a);
         cmp_addr(word_addr_b, m_a);
         cmp_data(rd_data, exp_d);
         cmp_data(rd_data_b, exp_d);
         cmp_lat(lat, 4'h9);
         cmp({10'h000, rd_valid_b, busy_b}, 12'h003);
      end
   end
   initial
   begin
      rstn = 1'b0;
      req = 1'b0;
      req_addr = 12'h000;
      void'($urandom(2));
      repeat (16) @(posedge sys_clk);
      rstn <= 1'b1;
      foreach (fixed[i]) do_read(fixed[i]);
      repeat (10) do_read(12'($urandom));
      req <= 1'b0;
      repeat (12) @(posedge sys_clk);
      req <= 1'b1;
      req_addr <= 12'h3A7;
      repeat (5) @(posedge sys_clk);
      rstn <= 1'b0;
      req <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      cmp({9'h0, busy, select_first, select_second}, 12'h1);
      do_read(12'h3A7);
      req <= 1'b0;
      repeat (12) @(posedge sys_clk);
      cmp(12'(exp_q.size()), 12'h000);
      end_sim();
   end
endmodule

// >>> mrp_host.sv
`timescale 1ns/100ps
// Operation
// (RL1) Drive a 12-bit word address selecting one of 4096 bytes.
// (RL2) Address bit 0 is least significant, bit 11 most significant.
// (RL3) Data bit 0 is least significant, bit 7 most; raw byte.
// (RL4) Memory drives data only while both selects are active.
// (RL5) Either select inactive floats the data lines.
// (RL6) Each select polarity is a fixed build-time setting.
// (RL7) Polarity 1 means active high, 0 active low, per select.
// (RL8) Output word holds while address and selects stay put.
// (RL9) Data is static; no strobe needed by the memory.
// (RL10) Sample no sooner than 450 ns after address stable.
// (RL11) Sample no sooner than 200 ns after selects become active.
// (RL12) Hold address a full read cycle; ignore data while accessing.
module mrp_host
#(
   parameter bit SEL1_ACT_HIGH = 1'b1,
   parameter bit SEL2_ACT_HIGH = 1'b1
)
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic req,
   input wire logic [mrp_pkg::ADDR_W-1:0] req_addr,
   output logic busy,
   output logic rd_valid,
   output logic [mrp_pkg::DATA_W-1:0] rd_data,
   output logic [mrp_pkg::ADDR_W-1:0] word_addr,
   output logic select_first,
   output logic select_second,
   input wire logic [mrp_pkg::DATA_W-1:0] rd_byte
);
   // ----------------------------------------
   // Select level helper
   // ----------------------------------------
   function automatic logic sel_level(input logic act_high,
                                      input logic on);
      sel_level = on ? act_high : ~act_high; // RL7
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      mrp_pkg::mrp_state_t st;
      mrp_pkg::mrp_pins_t pins;
      mrp_pkg::mrp_resp_t resp;
   } mrp_host_t;
   mrp_host_t s;
   mrp_host_t next_s;
   logic tmr_start;
   logic tmr_done;

   mrp_timer u_timer
   (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .start(tmr_start),
      .load(4'(mrp_pkg::WAIT_CYC)),
      .done(tmr_done)
   );

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      next_s = s;
      tmr_start = 1'b0;
      next_s.resp.valid = 1'b0;
      case (s.st)
         mrp_pkg::MRP_IDLE:
         begin
            if (req)
            begin
               next_s.pins.word_addr = req_addr; // RL1 RL2
               next_s.pins.select_first = sel_level(SEL1_ACT_HIGH, 1'b1);
               next_s.pins.select_second =
                  sel_level(SEL2_ACT_HIGH, 1'b1); // RL4 RL6
               next_s.resp.busy = 1'b1;
               tmr_start = 1'b1;
               next_s.st = mrp_pkg::MRP_WAIT;
            end
         end
         mrp_pkg::MRP_WAIT:
         begin
            // Data lines ignored until access time passes
            if (tmr_done) // RL10 RL11 RL12
            begin
               next_s.resp.data = rd_byte; // RL3 RL9
               next_s.resp.valid = 1'b1;
               next_s.st = mrp_pkg::MRP_HOLD;
            end
         end
         mrp_pkg::MRP_HOLD:
         begin
            // Release bus so other memories may drive it
            next_s.pins.select_first = sel_level(SEL1_ACT_HIGH, 1'b0);
            next_s.pins.select_second =
               sel_level(SEL2_ACT_HIGH, 1'b0); // RL5
            next_s.resp.busy = 1'b0;
            next_s.st = mrp_pkg::MRP_IDLE;
         end
         default:
            next_s.st = mrp_pkg::MRP_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         s.st <= mrp_pkg::MRP_IDLE;
         s.pins.word_addr <= mrp_pkg::ADDR_RST;
         s.pins.select_first <= ~SEL1_ACT_HIGH;
         s.pins.select_second <= ~SEL2_ACT_HIGH;
         s.resp.data <= mrp_pkg::DATA_RST;
         s.resp.valid <= 1'b0;
         s.resp.busy <= 1'b0;
      end
      else
         s <= next_s;
   end

   assign busy = s.resp.busy;
   assign rd_valid = s.resp.valid;
   assign rd_data = s.resp.data;
   assign word_addr = s.pins.word_addr;
   assign select_first = s.pins.select_first;
   assign select_second = s.pins.select_second;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   logic [3:0] act_cnt;
   always_ff @(posedge sys_clk)
   begin
      if (!rstn || s.st == mrp_pkg::MRP_IDLE)
         act_cnt <= 4'h0;
      else if (act_cnt != 4'hF)
         act_cnt <= act_cnt + 4'h1;
   end

   a_sample_after_access: assert property (@(posedge sys_clk) // RL10
      disable iff (!rstn) rd_valid |-> act_cnt >= 4'(mrp_pkg::ACC_ADDR_CYC))
      else $error("Sample before address access time");
   a_sample_after_select: assert property (@(posedge sys_clk) // RL11
      disable iff (!rstn) rd_valid |-> $past(select_first, 4) ==
      SEL1_ACT_HIGH && $past(select_second, 4) == SEL2_ACT_HIGH)
      else $error("Sample before select access time");
   a_addr_held: assert property (@(posedge sys_clk) // RL12
      disable iff (!rstn) (s.st == mrp_pkg::MRP_WAIT) |=> $stable(word_addr))
      else $error("Address changed during access");
   a_sel_active: assert property (@(posedge sys_clk) // RL4
      disable iff (!rstn) (s.st == mrp_pkg::MRP_WAIT) |->
      select_first == SEL1_ACT_HIGH && select_second == SEL2_ACT_HIGH)
      else $error("Selects not active during access");
   a_sel_release: assert property (@(posedge sys_clk) // RL5
      disable iff (!rstn) rd_valid |=> select_first != SEL1_ACT_HIGH &&
      select_second != SEL2_ACT_HIGH)
      else $error("Selects not released after read");
   a_data_capture: assert property (@(posedge sys_clk) // RL3
      disable iff (!rstn) rd_valid |-> rd_data == $past(rd_byte))
      else $error("Captured byte mismatch");
   a_valid_pulse: assert property (@(posedge sys_clk) // RL9
      disable iff (!rstn) rd_valid |=> !rd_valid)
      else $error("Valid longer than one cycle");
   a_req_addr: assert property (@(posedge sys_clk) // RL1
      disable iff (!rstn) (s.st == mrp_pkg::MRP_IDLE && req) |=>
      word_addr == $past(req_addr) ##9 rd_valid)
      else $error("Address or answer timing wrong");
endmodule

// >>> mrp_pkg.sv
package mrp_pkg;
   // ----------------------------------------
   // Geometry
   // ----------------------------------------
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int WORDS = 4096;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int T_ACC_ADDR_NS = 450;
   localparam int T_ACC_SEL_NS = 200;
   localparam int T_CYCLE_NS = 450;
   // Least times round up
   localparam int ACC_ADDR_CYC =
      (T_ACC_ADDR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACC_SEL_CYC =
      (T_ACC_SEL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYCLE_CYC =
      (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAIT_CYC =
      (ACC_ADDR_CYC > ACC_SEL_CYC) ? ACC_ADDR_CYC : ACC_SEL_CYC;
   localparam int CNT_W = 4;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
   localparam logic [CNT_W-1:0] CNT_RST = 4'h0;

   typedef enum logic [1:0] {MRP_IDLE, MRP_WAIT, MRP_HOLD} mrp_state_t;

   // Pins toward the memory
   typedef struct packed {
      logic [ADDR_W-1:0] word_addr;
      logic select_first;
      logic select_second;
   } mrp_pins_t;

   // Answer toward the user
   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic valid;
      logic busy;
   } mrp_resp_t;
endpackage

// >>> mrp_rom_model.sv
`timescale 1ns/100ps
module mrp_rom_model
#(
   parameter bit SEL1_ACT_HIGH = 1'b1,
   parameter bit SEL2_ACT_HIGH = 1'b1,
   parameter realtime T_ADDR = 445.0,
   parameter realtime T_SEL = 195.0
)
(
   input wire logic [mrp_pkg::ADDR_W-1:0] word_addr,
   input wire logic select_first,
   input wire logic select_second,
   output logic [mrp_pkg::DATA_W-1:0] rd_byte
);
   logic on;
   logic [7:0] junk;
   realtime t_a = 0.0;
   realtime t_s = 0.0;
   assign on = (select_first == SEL1_ACT_HIGH) &&
      (select_second == SEL2_ACT_HIGH);
   always @(word_addr)
   begin
      t_a = $realtime;
   end
   always @(on)
   begin
      t_s = $realtime;
   end
   // Garbage while deselected or still accessing
   initial
   begin
      junk = 8'hA5;
      rd_byte = junk;
      forever
      begin
         #5;
         if (on && ($realtime - t_a >= T_ADDR) &&
            ($realtime - t_s >= T_SEL))
            rd_byte = word_addr[7:0] ^ {word_addr[3:0],
               word_addr[11:8]} ^ 8'h3C;
         else
         begin
            junk = ~junk + 8'h01;
            rd_byte = junk;
         end
      end
   end
endmodule

// >>> mrp_timer.sv
`timescale 1ns/100ps
module mrp_timer
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic start,
   input wire logic [mrp_pkg::CNT_W-1:0] load,
   output logic done
);
   // ----------------------------------------
   // Down counter
   // ----------------------------------------
   typedef struct packed {
      logic [mrp_pkg::CNT_W-1:0] cnt;
      logic run;
   } mrp_tmr_t;
   mrp_tmr_t s;
   mrp_tmr_t next_s;

   always_comb
   begin
      next_s = s;
      if (start)
      begin
         next_s.cnt = load;
         next_s.run = 1'b1;
      end
      else if (s.run)
      begin
         next_s.cnt = s.cnt - 4'h1;
         if (s.cnt == 4'h1)
            next_s.run = 1'b0;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         s.cnt <= mrp_pkg::CNT_RST;
         s.run <= 1'b0;
      end
      else
         s <= next_s;
   end

   assign done = s.run && (s.cnt == 4'h1);
endmodule
